// ### design/loaacc_top.sv
// Loop one fast acquisition enables, clear-state strobes and Avalon register slave
`timescale 1ns/100ps
module loaacc_top #(
    parameter int HIST_W = 32
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         reset_in,
    // Avalon-MM slave
    input  wire logic [loaacc_pkg::AW-1:0]    avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [loaacc_pkg::DW-1:0]    avs_writedata_in,
    input  wire logic [3:0]                   avs_byteenable_in,
    output logic      [loaacc_pkg::DW-1:0]    avs_readdata_out,
    output logic                              avs_waitrequest_out,
    // Loop events and history
    input  wire loaacc_pkg::loaacc_loop_evt_t loop_evt_in,
    input  wire logic [HIST_W-1:0]            new_avg_word_in,
    // Autosync and mute conditions
    input  wire logic [3:0]                   autosync_cond_in,
    input  wire logic                         analog_locked_in,
    input  wire logic                         automute_trip_in,
    input  wire logic                         autounmute_met_in,
    // Loop controls
    output logic                              fast_acq_start_out,
    output logic                              history_erase_out,
    output logic                              history_avail_out,
    output logic                              mute_out,
    output logic                              output_sync_out,
    output logic                              irq_out
);
    import loaacc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic              wait_reg;
    logic [DW-1:0]     rdata_reg;
    logic [EN_W-1:0]   fa_en_reg;
    logic [RW-1:0]     clear_reg;
    logic [1:0]        as_mode_reg;
    logic [IRQ_W-1:0]  irq_st_reg;
    logic [IRQ_W-1:0]  irq_mk_reg;
    logic              irq_reg;
    logic              done_reg;
    logic              havail_reg;
    logic [HIST_W-1:0] hist_reg;
    logic              mute_reg;
    logic              start_reg;
    logic              erase_reg;
    logic              as_sync;
    logic              as_armed;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; one wait cycle, write lands when waitrequest is low
    wire logic          req      = avs_read_in | avs_write_in;
    wire logic          wait_nxt = ~(wait_reg & req);
    wire logic          wr_go    = avs_write_in & ~wait_reg & avs_byteenable_in[0];
    wire logic [RW-1:0] wd       = avs_writedata_in[RW-1:0];

    function automatic logic hit(input logic [AW-1:0] a, input logic [15:0] idx);
        return a == reg_addr(idx);
    endfunction

    wire logic sel_fa  = hit(avs_address_in, IDX_FA_EN);
    wire logic sel_clr = hit(avs_address_in, IDX_CLEAR);
    wire logic sel_as  = hit(avs_address_in, IDX_AS_CTL);
    wire logic sel_st  = hit(avs_address_in, IDX_STATUS);
    wire logic sel_ist = hit(avs_address_in, IDX_IRQ_ST);
    wire logic sel_imk = hit(avs_address_in, IDX_IRQ_MK);
    wire logic sel_hw  = hit(avs_address_in, IDX_HIST);

    wire logic wr_fa  = wr_go & sel_fa;
    wire logic wr_clr = wr_go & sel_clr;
    wire logic wr_as  = wr_go & sel_as;
    wire logic wr_ist = wr_go & sel_ist;
    wire logic wr_imk = wr_go & sel_imk;

    ////////////////////////////////////////////////////////////////////////
    // Clear-state strobes act on the write itself, never on stored bits
    wire logic clr_done = wr_clr & wd[CLR_DONE];
    wire logic clr_hist = wr_clr & wd[CLR_HIST];
    wire logic clr_mute = wr_clr & wd[CLR_MUTE];
    wire logic rearm    = wr_clr & wd[CLR_REARM];

    // Only bits 4, 2 and 1 hold a value; bits 7 to 5, 3 and 0 do not
    wire logic [RW-1:0] clear_nxt = wr_clr ? (wd & CLR_KEEP) : clear_reg;

    ////////////////////////////////////////////////////////////////////////
    // Fast acquisition qualification
    wire logic [EN_W-1:0] en_eff = (fa_en_reg == '0) ? '1 : fa_en_reg;

    wire logic exit_ok   = (loop_evt_in.exit_holdover & en_eff[EN_HOLDOVER])
                         | (loop_evt_in.exit_freerun & en_eff[EN_FREERUN]);
    wire logic first_blk = en_eff[EN_FIRST] & done_reg;
    wire logic sync_blk  = en_eff[EN_NOSYNC] & loop_evt_in.outputs_syncing;
    wire logic start_nxt = exit_ok & ~first_blk & ~sync_blk;

    ////////////////////////////////////////////////////////////////////////
    // Flags; a set in the clearing cycle wins
    wire logic done_nxt   = loop_evt_in.acq_done_set | (done_reg & ~clr_done);
    wire logic havail_nxt = loop_evt_in.new_avg_valid | (havail_reg & ~clr_hist);
    wire logic [HIST_W-1:0] hist_nxt = loop_evt_in.new_avg_valid ? new_avg_word_in
                                                                 : hist_reg;
    // Re-applied mute holds until the unmute condition, which cannot beat the clear
    wire logic mute_nxt = clr_mute | automute_trip_in
                        | (mute_reg & ~autounmute_met_in);

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events, sticky, write one to clear
    wire logic [IRQ_W-1:0] irq_ev = {as_sync, loop_evt_in.new_avg_valid,
                                     loop_evt_in.acq_done_set, start_nxt};
    wire logic [IRQ_W-1:0] irq_clr = wr_ist ? wd[IRQ_W-1:0] : '0;
    logic      [IRQ_W-1:0] irq_st_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_irq
            assign irq_st_nxt[gi] = irq_ev[gi] | (irq_st_reg[gi] & ~irq_clr[gi]);
        end
    endgenerate

    wire logic [IRQ_W-1:0] irq_mk_nxt = wr_imk ? wd[IRQ_W-1:0] : irq_mk_reg;
    wire logic irq_nxt = |(irq_st_reg & irq_mk_reg);

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    wire logic [RW-1:0] st_val = {4'h0, as_armed, mute_reg, havail_reg, done_reg};
    wire logic [DW-1:0] rd_mux =
        sel_fa  ? DW'(fa_en_reg)  :
        sel_clr ? DW'(clear_reg)  :
        sel_as  ? DW'(as_mode_reg) :
        sel_st  ? DW'(st_val)     :
        sel_ist ? DW'(irq_st_reg) :
        sel_imk ? DW'(irq_mk_reg) :
        sel_hw  ? DW'(hist_reg)   : 32'h0000_0000;
    wire logic [DW-1:0] rdata_nxt = (wait_reg & avs_read_in) ? rd_mux : rdata_reg;

    // Condition chosen by the autosync mode
    wire logic as_cond = autosync_cond_in[as_mode_reg];

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg  <= wait_nxt;
            rdata_reg <= rdata_nxt;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            fa_en_reg   <= FA_EN_RST;
            clear_reg   <= CLEAR_RST;
            as_mode_reg <= AS_CTL_RST;
            irq_mk_reg  <= IRQ_MK_RST;
        end else begin
            fa_en_reg   <= wr_fa ? wd[EN_W-1:0] : fa_en_reg;
            clear_reg   <= clear_nxt;
            as_mode_reg <= wr_as ? wd[1:0] : as_mode_reg;
            irq_mk_reg  <= irq_mk_nxt;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            done_reg   <= 1'b0;
            havail_reg <= 1'b0;
            hist_reg   <= '0;
            mute_reg   <= 1'b0;
        end else begin
            done_reg   <= done_nxt;
            havail_reg <= havail_nxt;
            hist_reg   <= hist_nxt;
            mute_reg   <= mute_nxt;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            start_reg  <= 1'b0;
            erase_reg  <= 1'b0;
            irq_st_reg <= '0;
            irq_reg    <= 1'b0;
        end else begin
            start_reg  <= start_nxt;
            erase_reg  <= clr_hist;
            irq_st_reg <= irq_st_nxt;
            irq_reg    <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Autosync one-shot
    loaacc_autosync u_autosync (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .mode_in   (as_mode_reg),
        .cond_in   (as_cond),
        .rearm_in  (rearm),
        .locked_in (analog_locked_in),
        .sync_out  (as_sync),
        .armed_out (as_armed)
    );

    assign avs_readdata_out    = rdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign fast_acq_start_out  = start_reg;
    assign history_erase_out   = erase_reg;
    assign history_avail_out   = havail_reg;
    assign mute_out            = mute_reg;
    assign output_sync_out     = as_sync;
    assign irq_out             = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence clr_read_s;
        avs_read_in && sel_clr && wait_reg;
    endsequence
    sequence hist_clear_s;
        clr_hist && !loop_evt_in.new_avg_valid;
    endsequence

    first_only_a: assert property (
        en_eff[EN_FIRST] && done_reg |=> !fast_acq_start_out)
        else $error("acquisition started after done");
    all_zero_a: assert property (
        fa_en_reg == 4'h0 && loop_evt_in.exit_holdover && !done_reg
        && !loop_evt_in.outputs_syncing |=> fast_acq_start_out)
        else $error("zero enables did not act as all set");
    holdover_gate_a: assert property (
        fa_en_reg != 4'h0 && !fa_en_reg[EN_HOLDOVER] && !loop_evt_in.exit_freerun
        |=> !fast_acq_start_out)
        else $error("holdover exit started acquisition");
    freerun_gate_a: assert property (
        fa_en_reg != 4'h0 && !fa_en_reg[EN_FREERUN] && !loop_evt_in.exit_holdover
        |=> !fast_acq_start_out)
        else $error("freerun exit started acquisition");
    no_sync_a: assert property (
        en_eff[EN_NOSYNC] && loop_evt_in.outputs_syncing |=> !fast_acq_start_out)
        else $error("acquisition started during output sync");
    mute_clear_a: assert property (
        clr_mute |=> mute_out ##1 (mute_out || $past(autounmute_met_in)))
        else $error("mute not re-applied by clear");
    done_clear_a: assert property (
        clr_done && !loop_evt_in.acq_done_set |=> !done_reg)
        else $error("done flag survived clear");
    history_clear_a: assert property (
        hist_clear_s |=> !history_avail_out && history_erase_out)
        else $error("history clear incomplete");
    history_keep_a: assert property (
        !loop_evt_in.new_avg_valid |=> $stable(hist_reg))
        else $error("history word changed without average");
    history_new_a: assert property (
        loop_evt_in.new_avg_valid |=> history_avail_out
        && hist_reg == $past(new_avg_word_in))
        else $error("new average not captured");
    immediate_sync_a: assert property (
        rearm && as_mode_reg == AS_IMMEDIATE && analog_locked_in |=> output_sync_out)
        else $error("immediate sync missing");
    strobe_read_a: assert property (
        clr_read_s |=> avs_readdata_out[CLR_DONE] == 1'b0
        && avs_readdata_out[CLR_REARM] == 1'b0)
        else $error("strobe bit read back as one");
    reserved_read_a: assert property (
        clr_read_s |=> avs_readdata_out[7:5] == 3'h0)
        else $error("reserved bits read nonzero");
    bus_wait_a: assert property (
        req && wait_reg |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest handshake broken");
    irq_level_a: assert property (
        |(irq_st_reg & irq_mk_reg) |=> irq_out)
        else $error("interrupt not raised");
endmodule

// ### include/loaacc_pkg.sv
// Package: register map, fields, carriers and types of the loop one acquisition control
package loaacc_pkg;
    localparam int AW = 18;
    localparam int DW = 32;
    localparam int RW = 8;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_FA_EN  = 16'h2206;
    localparam logic [15:0] IDX_CLEAR  = 16'h2207;
    localparam logic [15:0] IDX_AS_CTL = 16'h2208;
    localparam logic [15:0] IDX_STATUS = 16'h2209;
    localparam logic [15:0] IDX_IRQ_ST = 16'h220A;
    localparam logic [15:0] IDX_IRQ_MK = 16'h220B;
    localparam logic [15:0] IDX_HIST   = 16'h220C;

    ////////////////////////////////////////////////////////////////////////
    // Fast acquisition enable fields
    localparam int EN_FREERUN  = 0;
    localparam int EN_HOLDOVER = 1;
    localparam int EN_FIRST    = 2;
    localparam int EN_NOSYNC   = 3;
    localparam int EN_W        = 4;
    // Clear-state fields
    localparam int CLR_REARM = 0;
    localparam int CLR_HIST  = 1;
    localparam int CLR_DONE  = 3;
    localparam int CLR_MUTE  = 4;
    localparam logic [RW-1:0] CLR_KEEP = 8'h16;
    // Loop status fields
    localparam int ST_DONE   = 0;
    localparam int ST_HAVAIL = 1;
    localparam int ST_MUTE   = 2;
    localparam int ST_ARMED  = 3;
    // Interrupt events
    localparam int IRQ_START = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_AVG   = 2;
    localparam int IRQ_SYNC  = 3;
    localparam int IRQ_W     = 4;
    // Autosync mode
    localparam int             AS_MODE_W    = 2;
    localparam logic [1:0]     AS_OFF       = 2'h0;
    localparam logic [1:0]     AS_IMMEDIATE = 2'h1;
    // Reset values
    localparam logic [EN_W-1:0]  FA_EN_RST  = 4'h0;
    localparam logic [RW-1:0]    CLEAR_RST  = 8'h00;
    localparam logic [1:0]       AS_CTL_RST = 2'h0;
    localparam logic [IRQ_W-1:0] IRQ_MK_RST = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic exit_holdover;
        logic exit_freerun;
        logic outputs_syncing;
        logic acq_done_set;
        logic new_avg_valid;
    } loaacc_loop_evt_t;

    typedef enum logic {AS_ARMED, AS_SPENT} loaacc_as_state_t;

    function automatic logic [AW-1:0] reg_addr(input logic [15:0] idx);
        return {idx, 2'b00};
    endfunction
endpackage

// ### design/loaacc_autosync.sv
// Autosync one-shot for channel one outputs
`timescale 1ns/100ps
module loaacc_autosync (
    // Clock and reset
    input  wire logic                             clk_in,
    input  wire logic                             reset_in,
    // Control
    input  wire logic [loaacc_pkg::AS_MODE_W-1:0] mode_in,
    input  wire logic                             cond_in,
    input  wire logic                             rearm_in,
    input  wire logic                             locked_in,
    // Results
    output logic                                  sync_out,
    output logic                                  armed_out
);
    import loaacc_pkg::*;

    loaacc_as_state_t state_reg;
    loaacc_as_state_t state_next;
    logic             cond_reg;
    logic             sync_reg;

    wire logic cond_rise = cond_in & ~cond_reg;
    wire logic enabled   = mode_in != AS_OFF;
    wire logic fire_now  = rearm_in & (mode_in == AS_IMMEDIATE) & locked_in;
    wire logic fire_auto = (state_reg == AS_ARMED) & enabled & cond_rise;
    wire logic sync_next = fire_now | fire_auto;

    always_comb begin
        unique case (state_reg)
            AS_ARMED: state_next = sync_next ? AS_SPENT : AS_ARMED;
            AS_SPENT: state_next = (rearm_in & ~fire_now) ? AS_ARMED : AS_SPENT;
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= AS_ARMED;
            cond_reg  <= 1'b0;
            sync_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cond_reg  <= cond_in;
            sync_reg  <= sync_next;
        end
    end

    assign sync_out  = sync_reg;
    assign armed_out = state_reg == AS_ARMED;

    ////////////////////////////////////////////////////////////////////////
    sequence rearmed_s;
        rearm_in && !(mode_in == AS_IMMEDIATE && locked_in);
    endsequence
    sequence qualifying_s;
        enabled && cond_rise && !rearm_in;
    endsequence

    spent_once_a: assert property (@(posedge clk_in) disable iff (reset_in)
        state_reg == AS_SPENT && !rearm_in |=> !sync_out)
        else $error("autosync fired while spent");
    rearm_resync_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rearmed_s ##1 qualifying_s |=> sync_out)
        else $error("rearmed autosync missed event");
endmodule

// ### verification/loaacc_top_bench.sv
// Self-checking bench for the loop one acquisition enables and clear-state strobes
`timescale 1ns/100ps
module loaacc_top_bench;
    import loaacc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic             clk_in            = 1'b0;
    logic             reset_in          = 1'b1;
    logic [AW-1:0]    avs_address_in    = '0;
    logic             avs_read_in       = 1'b0;
    logic             avs_write_in      = 1'b0;
    logic [DW-1:0]    avs_writedata_in  = '0;
    logic [3:0]       avs_byteenable_in = 4'hF;
    logic [DW-1:0]    avs_readdata_out;
    logic             avs_waitrequest_out;
    loaacc_loop_evt_t loop_evt_in       = '0;
    logic [31:0]      new_avg_word_in   = '0;
    logic [3:0]       autosync_cond_in  = '0;
    logic             analog_locked_in  = 1'b0;
    logic             automute_trip_in  = 1'b0;
    logic             autounmute_met_in = 1'b0;
    logic             fast_acq_start_out;
    logic             history_erase_out;
    logic             history_avail_out;
    logic             mute_out;
    logic             output_sync_out;
    logic             irq_out;
    logic             sync_lvl          = 1'b0;
    int               num_errors        = 0;
    int               checks            = 0;
    int               n_start           = 0;
    int               n_erase           = 0;
    int               n_sync            = 0;
    int               c;

    always #12.5 clk_in = ~clk_in;

    loaacc_top #(.HIST_W(32)) u_dut (
        .clk_in(clk_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .loop_evt_in(loop_evt_in), .new_avg_word_in(new_avg_word_in),
        .autosync_cond_in(autosync_cond_in), .analog_locked_in(analog_locked_in),
        .automute_trip_in(automute_trip_in), .autounmute_met_in(autounmute_met_in),
        .fast_acq_start_out(fast_acq_start_out), .history_erase_out(history_erase_out),
        .history_avail_out(history_avail_out), .mute_out(mute_out),
        .output_sync_out(output_sync_out), .irq_out(irq_out)
    );

    // Pulse counters, so single-cycle outputs are never missed
    always @(posedge clk_in) begin
        n_start += (fast_acq_start_out === 1'b1);
        n_erase += (history_erase_out === 1'b1);
        n_sync  += (output_sync_out === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    // Leading edge keeps a released request low for a full cycle
    // No local limit on waitrequest: only the watchdog ends a hung transfer
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_in);
        avs_address_in   <= {idx, 2'b00};
        avs_writedata_in <= {24'h000000, d};
        avs_write_in     <= wr;
        avs_read_in      <= ~wr;
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(what, exp, q);
    endtask

    task automatic evt(input logic [4:0] e);
        loaacc_loop_evt_t v;
        v = loaacc_loop_evt_t'(e);
        v.outputs_syncing = sync_lvl;
        @(posedge clk_in);
        loop_evt_in <= v;
        v = '0;
        v.outputs_syncing = sync_lvl;
        @(posedge clk_in);
        loop_evt_in <= v;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic acq(input logic [4:0] e, input int exp);
        int c0;
        c0 = n_start;
        evt(e);
        chk("fast_acq_start pulses", 32'(exp), 32'(n_start - c0));
    endtask

    task automatic cond_pulse(input logic [3:0] v);
        autosync_cond_in <= v;
        repeat (3) @(posedge clk_in);
        autosync_cond_in <= 4'h0;
        repeat (3) @(posedge clk_in);
    endtask

    task automatic unmute;
        autounmute_met_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        autounmute_met_in <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk_in);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        chk("waitrequest in reset", 32'h1, 32'(avs_waitrequest_out));
        reset_in <= 1'b0;
        rd_chk("enable reg", IDX_FA_EN, 32'h0);
        rd_chk("clear reg", IDX_CLEAR, 32'h0);
        rd_chk("autosync mode", IDX_AS_CTL, 32'h0);
        rd_chk("irq mask", IDX_IRQ_MK, 32'h0);
        rd_chk("status", IDX_STATUS, 32'h8);
        rd_chk("unmapped", 16'h2210, 32'h0);
        $display("test reset_values done");
        // Enable selection
        acq(5'h10, 1);
        acq(5'h08, 1);
        wr(IDX_FA_EN, 8'h02);
        acq(5'h10, 1);
        acq(5'h08, 0);
        wr(IDX_FA_EN, 8'h01);
        acq(5'h08, 1);
        acq(5'h10, 0);
        avs_byteenable_in <= 4'hE;
        wr(IDX_FA_EN, 8'h0F);
        avs_byteenable_in <= 4'hF;
        rd_chk("enable after lane-off write", IDX_FA_EN, 32'h1);
        wr(IDX_FA_EN, 8'h0A);
        sync_lvl = 1'b1;
        acq(5'h10, 0);
        sync_lvl = 1'b0;
        acq(5'h10, 1);
        $display("test enables done");
        // First-only and done clear
        wr(IDX_FA_EN, 8'h06);
        evt(5'h02);
        rd_chk("status done", IDX_STATUS, 32'h9);
        acq(5'h10, 0);
        wr(IDX_FA_EN, 8'h02);
        acq(5'h10, 1);
        wr(IDX_CLEAR, 8'h08);
        rd_chk("status done cleared", IDX_STATUS, 32'h8);
        rd_chk("done strobe readback", IDX_CLEAR, 32'h0);
        wr(IDX_FA_EN, 8'h06);
        acq(5'h10, 1);
        $display("test first_only done");
        // History clear keeps the visible word
        new_avg_word_in <= 32'h12345678;
        evt(5'h01);
        rd_chk("status avail", IDX_STATUS, 32'hA);
        rd_chk("history word", IDX_HIST, 32'h12345678);
        c = n_erase;
        wr(IDX_CLEAR, 8'h02);
        rd_chk("status history cleared", IDX_STATUS, 32'h8);
        chk("history_avail after clear", 32'h0, 32'(history_avail_out));
        chk("erase pulses", 32'h1, 32'(n_erase - c));
        rd_chk("history word kept", IDX_HIST, 32'h12345678);
        new_avg_word_in <= 32'h0BADF00D;
        evt(5'h01);
        rd_chk("status new avail", IDX_STATUS, 32'hA);
        chk("history_avail after average", 32'h1, 32'(history_avail_out));
        rd_chk("history word new", IDX_HIST, 32'h0BADF00D);
        $display("test history done");
        // Mute clear re-applies muting
        automute_trip_in <= 1'b1;
        @(posedge clk_in);
        automute_trip_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk("mute set", 32'h1, 32'(mute_out));
        unmute();
        chk("mute released", 32'h0, 32'(mute_out));
        wr(IDX_CLEAR, 8'h10);
        repeat (2) @(posedge clk_in);
        chk("mute reapplied", 32'h1, 32'(mute_out));
        unmute();
        chk("mute released again", 32'h0, 32'(mute_out));
        $display("test mute done");
        // Autosync one-shot and rearm; mode off first
        c = n_sync;
        cond_pulse(4'hF);
        chk("autosync while off", 32'h0, 32'(n_sync - c));
        wr(IDX_AS_CTL, 8'h02);
        c = n_sync;
        cond_pulse(4'h4);
        cond_pulse(4'h4);
        chk("single autosync", 32'h1, 32'(n_sync - c));
        rd_chk("status spent", IDX_STATUS, 32'h2);
        wr(IDX_CLEAR, 8'h01);
        rd_chk("status rearmed", IDX_STATUS, 32'hA);
        rd_chk("rearm strobe readback", IDX_CLEAR, 32'h0);
        cond_pulse(4'h4);
        chk("resync after rearm", 32'h2, 32'(n_sync - c));
        // Condition rising the cycle right after the rearm strobe
        wr(IDX_CLEAR, 8'h01);
        cond_pulse(4'h4);
        chk("resync right after rearm", 32'h3, 32'(n_sync - c));
        wr(IDX_AS_CTL, 8'h01);
        c = n_sync;
        wr(IDX_CLEAR, 8'h01);
        repeat (2) @(posedge clk_in);
        chk("immediate sync unlocked", 32'h0, 32'(n_sync - c));
        analog_locked_in <= 1'b1;
        wr(IDX_CLEAR, 8'h01);
        repeat (2) @(posedge clk_in);
        chk("immediate sync locked", 32'h1, 32'(n_sync - c));
        wr(IDX_CLEAR, 8'hFF);
        rd_chk("clear reg reserved", IDX_CLEAR, 32'h16);
        $display("test autosync done");
        // Interrupt mask and write-one-to-clear
        chk("irq masked", 32'h0, 32'(irq_out));
        rd_chk("irq status", IDX_IRQ_ST, 32'hF);
        wr(IDX_IRQ_MK, 8'h04);
        repeat (2) @(posedge clk_in);
        chk("irq raised", 32'h1, 32'(irq_out));
        wr(IDX_IRQ_ST, 8'h04);
        repeat (2) @(posedge clk_in);
        chk("irq cleared", 32'h0, 32'(irq_out));
        rd_chk("irq status after clear", IDX_IRQ_ST, 32'hB);
        $display("test interrupts done");
        tally_and_finish();
    end
endmodule
